/* ssb_pkg.sv */
// Constants, types and register map of the stop and brake sequencer.
package ssb_pkg;

  localparam int CLK_HZ = 125000000;
  localparam int TICK_MS = 10;
  localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;

  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STOP_DELAY = 8'h04;
  localparam logic [7:0] ADDR_SPEED_THR = 8'h08;
  localparam logic [7:0] ADDR_TIMEOUT = 8'h0c;
  localparam logic [7:0] ADDR_MAX_SPEED = 8'h10;
  localparam logic [7:0] ADDR_OTHER_OUT = 8'h14;
  localparam logic [7:0] ADDR_STATUS = 8'h18;

  localparam int CTRL_STOP_MODE_LSB = 0;
  localparam int CTRL_SEQ_DIS_BIT = 2;
  localparam int CTRL_TERM_LSB = 4;

  localparam logic [1:0] STOP_MODE_RESET = 2'h2;
  localparam logic [1:0] TERM_SEL_RESET = 2'h0;
  localparam logic [5:0] STOP_DELAY_RESET = 6'h00;
  localparam logic [5:0] STOP_DELAY_MAX = 6'h32;
  localparam logic [13:0] SPEED_THR_RESET = 14'h0064;
  localparam logic [13:0] SPEED_THR_MAX = 14'h2710;
  localparam logic [6:0] TIMEOUT_RESET = 7'h32;
  localparam logic [6:0] TIMEOUT_MIN = 7'h0a;
  localparam logic [6:0] TIMEOUT_MAX = 7'h64;
  localparam logic [13:0] MAX_SPEED_RESET = 14'h0bb8;
  localparam logic [13:0] CRAWL_SPEED_RESET = 14'h000a;

  typedef enum logic [1:0] {
    ST_OFF,
    ST_ON,
    ST_STOP_STILL,
    ST_STOP_MOVING
  } ssb_state_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } ssb_apb_req_t;

endpackage

/* ssb_tick_div.sv */
// Divider that gives one enable pulse per sequencing time step.
`timescale 1ns/10ps
module ssb_tick_div #(
  parameter int DIV = 1250000
) (
  input wire logic clk,  // System clock.
  input wire logic srst,  // Synchronous reset, active high.
  input wire logic clr,  // Restarts the step from zero.
  output logic tick  // One-cycle pulse at the end of each step.
);

  typedef struct packed {
    logic [31:0] cnt;
    logic tick;
  } ssb_div_state_t;

  ssb_div_state_t r;
  ssb_div_state_t n;

  initial
  begin
    if (DIV < 2)
    begin
      $error("ssb_tick_div: DIV must be at least 2");
    end
  end

  always_comb
  begin
    n = r;
    n.tick = 1'b0;
    if (clr)
    begin
      n.cnt = 32'h0;
    end
    else if (r.cnt == 32'(DIV - 1))
    begin
      n.cnt = 32'h0;
      n.tick = 1'b1;
    end
    else
    begin
      n.cnt = r.cnt + 32'h1;
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      r <= '0;
    end
    else
    begin
      r <= n;
    end
  end

  assign tick = r.tick;

endmodule

/* ssb_sequencer.sv */
// Stop method and holding-brake sequencer with its APB register file.
//
// Added by the designer: the APB register port and the address map.
`timescale 1ns/10ps
module ssb_sequencer #(
  parameter int TICK_CYCLES = ssb_pkg::TICK_CYCLES,
  parameter logic [13:0] CRAWL_SPEED = ssb_pkg::CRAWL_SPEED_RESET
) (
  input wire logic clk,  // System clock, 125 MHz.
  input wire logic srst,  // Synchronous reset, active high.
  input ssb_pkg::ssb_apb_req_t apbReq,  // APB request group.
  output logic pready,  // APB ready, always high.
  output logic [31:0] prdata,  // APB read data.
  output logic pslverr,  // APB error on unmapped address.
  input wire logic servoOnCmd,  // Host servo-on request pulse.
  input wire logic servoOffCmd,  // Host servo-off request pulse.
  input wire logic alarmPin,  // Servo alarm, asynchronous level.
  input wire logic powerLossPin,  // Control and main power gone.
  input wire logic [13:0] motorSpeed,  // Absolute motor speed, r/min.
  output logic driveEnable,  // Motor output stage enabled.
  output logic dynBrakeOn,  // Dynamic brake engaged.
  output logic brakeRelease_n,  // Low releases the holding brake.
  output logic [2:0] outCircuit_n  // Output circuits 1..3, low is on.
);

  // All state lives in one packed struct: register file, stop sequence and
  // pin synchronisers. A stop that starts in motion in mode 0 or 1 records in dbUsed that
  // it braked, because by the time the motor rests the speed no longer
  // tells whether the dynamic brake must stay engaged.
  typedef struct packed {
    ssb_pkg::ssb_state_t st;
    logic drive;
    logic db;
    logic brk;
    logic dbUsed;
    logic [6:0] cnt;
    logic [1:0] stopMode;
    logic seqDis;
    logic [1:0] termSel;
    logic [5:0] dlyReg;
    logic [13:0] thrReg;
    logic [6:0] tmoReg;
    logic [13:0] maxSpd;
    logic [2:0] otherReg;
    logic [1:0] alarmSync;
    logic [1:0] pwrSync;
    logic [31:0] rdata;
  } ssb_seq_state_t;

  ssb_seq_state_t r;
  ssb_seq_state_t n;
  logic tick;
  logic tickClr;
  logic alarm;
  logic pwrLoss;
  logic moving;
  logic offEvent;
  logic [13:0] effThr;
  logic mapped;
  logic wrEn;
  logic rdSetup;
  logic [31:0] rdVal;
  logic [2:0] circuitOn;
  logic belowThr;
  logic hardCut;
  logic [6:0] stepNext;

  initial
  begin
    if (TICK_CYCLES < 2)
    begin
      $error("ssb_sequencer: TICK_CYCLES must be at least 2");
    end
    // A crawl limit at the top of the speed range would class every
    // stop as still, so the stop method could never brake.
    if (CRAWL_SPEED >= ssb_pkg::SPEED_THR_MAX)
    begin
      $error("ssb_sequencer: CRAWL_SPEED is out of range");
    end
  end

  ssb_tick_div #(
    .DIV(TICK_CYCLES)
  ) u_tick (
    .clk(clk),
    .srst(srst),
    .clr(tickClr),
    .tick(tick)
  );

  // Only the second stage of each pin synchroniser is read.
  assign alarm = r.alarmSync[1];
  assign pwrLoss = r.pwrSync[1];
  // A crawling motor counts as still, so no braking energy is expected.
  assign moving = motorSpeed > CRAWL_SPEED;
  assign offEvent = servoOffCmd | alarm | pwrLoss;
  // Alarm and power loss skip the stop delay of a still stop; the axis may sag meanwhile.
  assign hardCut = alarm | pwrLoss;
  assign belowThr = motorSpeed < effThr;
  assign stepNext = r.cnt + 7'h1;

  always_comb
  begin
    effThr = r.thrReg;
    if (r.thrReg > r.maxSpd)
    begin
      effThr = r.maxSpd;
    end
  end

  assign mapped = (apbReq.paddr == ssb_pkg::ADDR_CTRL) ||
                  (apbReq.paddr == ssb_pkg::ADDR_STOP_DELAY) ||
                  (apbReq.paddr == ssb_pkg::ADDR_SPEED_THR) ||
                  (apbReq.paddr == ssb_pkg::ADDR_TIMEOUT) ||
                  (apbReq.paddr == ssb_pkg::ADDR_MAX_SPEED) ||
                  (apbReq.paddr == ssb_pkg::ADDR_OTHER_OUT) ||
                  (apbReq.paddr == ssb_pkg::ADDR_STATUS);
  assign wrEn = apbReq.psel & apbReq.penable & apbReq.pwrite & mapped;
  assign rdSetup = apbReq.psel & ~apbReq.penable & ~apbReq.pwrite;
  assign pready = 1'b1;
  assign pslverr = apbReq.psel & apbReq.penable & ~mapped;
  assign prdata = r.rdata;

  always_comb
  begin
    rdVal = 32'h0;
    case (apbReq.paddr)
      ssb_pkg::ADDR_CTRL:
      begin
        rdVal[ssb_pkg::CTRL_STOP_MODE_LSB +: 2] = r.stopMode;
        rdVal[ssb_pkg::CTRL_SEQ_DIS_BIT] = r.seqDis;
        rdVal[ssb_pkg::CTRL_TERM_LSB +: 2] = r.termSel;
      end
      ssb_pkg::ADDR_STOP_DELAY: rdVal[5:0] = r.dlyReg;
      ssb_pkg::ADDR_SPEED_THR: rdVal[13:0] = r.thrReg;
      ssb_pkg::ADDR_TIMEOUT: rdVal[6:0] = r.tmoReg;
      ssb_pkg::ADDR_MAX_SPEED: rdVal[13:0] = r.maxSpd;
      ssb_pkg::ADDR_OTHER_OUT: rdVal[2:0] = r.otherReg;
      ssb_pkg::ADDR_STATUS:
      begin
        rdVal[1:0] = r.st;
        rdVal[2] = r.drive;
        rdVal[3] = r.db;
        rdVal[4] = r.brk;
        rdVal[5] = alarm;
        rdVal[6] = pwrLoss;
        rdVal[14:8] = r.cnt;
      end
      default: rdVal = 32'h0;
    endcase
  end

  always_comb
  begin
    n = r;
    tickClr = 1'b0;
    n.alarmSync = {r.alarmSync[0], alarmPin};
    n.pwrSync = {r.pwrSync[0], powerLossPin};
    if (rdSetup)
    begin
      n.rdata = rdVal;
    end
    if (wrEn)
    begin
      case (apbReq.paddr)
        ssb_pkg::ADDR_CTRL:
        begin
          n.stopMode = apbReq.pwdata[ssb_pkg::CTRL_STOP_MODE_LSB +: 2];
          n.seqDis = apbReq.pwdata[ssb_pkg::CTRL_SEQ_DIS_BIT];
          n.termSel = apbReq.pwdata[ssb_pkg::CTRL_TERM_LSB +: 2];
        end
        ssb_pkg::ADDR_STOP_DELAY:
        begin
          if (apbReq.pwdata > 32'(ssb_pkg::STOP_DELAY_MAX))
          begin
            n.dlyReg = ssb_pkg::STOP_DELAY_MAX;
          end
          else
          begin
            n.dlyReg = apbReq.pwdata[5:0];
          end
        end
        ssb_pkg::ADDR_SPEED_THR:
        begin
          if (apbReq.pwdata > 32'(ssb_pkg::SPEED_THR_MAX))
          begin
            n.thrReg = ssb_pkg::SPEED_THR_MAX;
          end
          else
          begin
            n.thrReg = apbReq.pwdata[13:0];
          end
        end
        ssb_pkg::ADDR_TIMEOUT:
        begin
          if (apbReq.pwdata < 32'(ssb_pkg::TIMEOUT_MIN))
          begin
            n.tmoReg = ssb_pkg::TIMEOUT_MIN;
          end
          else if (apbReq.pwdata > 32'(ssb_pkg::TIMEOUT_MAX))
          begin
            n.tmoReg = ssb_pkg::TIMEOUT_MAX;
          end
          else
          begin
            n.tmoReg = apbReq.pwdata[6:0];
          end
        end
        ssb_pkg::ADDR_MAX_SPEED: n.maxSpd = apbReq.pwdata[13:0];
        ssb_pkg::ADDR_OTHER_OUT: n.otherReg = apbReq.pwdata[2:0];
        default: n.maxSpd = r.maxSpd;
      endcase
    end

    case (r.st)
      ssb_pkg::ST_OFF:
      begin
        n.drive = 1'b0;
        n.brk = 1'b0;
        if (servoOnCmd & ~offEvent)
        begin
          n.st = ssb_pkg::ST_ON;
          n.drive = 1'b1;
          n.brk = 1'b1;
          n.dbUsed = 1'b0;
        end
      end
      ssb_pkg::ST_ON:
      begin
        if (offEvent)
        begin
          // Restart the step divider so the first step is a full period.
          tickClr = 1'b1;
          n.cnt = 7'h0;
          // Modes 2 and 3 and a still motor get the dynamic brake only on power loss.
          n.dbUsed = moving & ~r.stopMode[1];
          if (r.seqDis)
          begin
            n.st = ssb_pkg::ST_OFF;
            n.drive = 1'b0;
            n.brk = 1'b0;
          end
          else if (moving)
          begin
            n.st = ssb_pkg::ST_STOP_MOVING;
            n.drive = 1'b0;
          end
          else
          begin
            n.brk = 1'b0;
            if (hardCut | (r.dlyReg == 6'h0))
            begin
              n.st = ssb_pkg::ST_OFF;
              n.drive = 1'b0;
            end
            else
            begin
              n.st = ssb_pkg::ST_STOP_STILL;
            end
          end
        end
      end
      ssb_pkg::ST_STOP_STILL:
      begin
        n.brk = 1'b0;
        if (tick)
        begin
          n.cnt = stepNext;
        end
        if (hardCut | (tick & (stepNext >= {1'b0, r.dlyReg})))
        begin
          n.st = ssb_pkg::ST_OFF;
          n.drive = 1'b0;
        end
      end
      ssb_pkg::ST_STOP_MOVING:
      begin
        n.drive = 1'b0;
        if (tick)
        begin
          n.cnt = stepNext;
        end
        // Whichever comes first, slow speed or timeout, applies the brake.
        if (belowThr | (tick & (stepNext >= r.tmoReg)))
        begin
          n.st = ssb_pkg::ST_OFF;
          n.brk = 1'b0;
        end
      end
      default:
      begin
        n.st = ssb_pkg::ST_OFF;
        n.drive = 1'b0;
        n.brk = 1'b0;
      end
    endcase

    // Mode 1 drops the brake once the motor is still; mode 0 keeps it.
    if (n.st == ssb_pkg::ST_ON)
    begin
      n.db = 1'b0;
    end
    else if (pwrLoss)
    begin
      n.db = 1'b1;
    end
    else
    begin
      n.db = n.dbUsed & ((r.stopMode == 2'h0) | moving);
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      r <= '0;
      r.st <= ssb_pkg::ST_OFF;
      r.stopMode <= ssb_pkg::STOP_MODE_RESET;
      r.termSel <= ssb_pkg::TERM_SEL_RESET;
      r.dlyReg <= ssb_pkg::STOP_DELAY_RESET;
      r.thrReg <= ssb_pkg::SPEED_THR_RESET;
      r.tmoReg <= ssb_pkg::TIMEOUT_RESET;
      r.maxSpd <= ssb_pkg::MAX_SPEED_RESET;
    end
    else
    begin
      r <= n;
    end
  end

  // Each circuit is the OR of its other signal and the brake signal when termSel selects it.
  always_comb
  begin
    for (int i = 0; i < 3; i++)
    begin
      circuitOn[i] = r.otherReg[i] |
                     (r.brk & (r.termSel == 2'(i + 1)));
    end
  end

  assign outCircuit_n = ~circuitOn;
  assign brakeRelease_n = ~r.brk;
  assign driveEnable = r.drive;
  assign dynBrakeOn = r.db;

endmodule

/* ssb_monitor.sv */
// Concurrent checks on the ports of the stop and brake sequencer.
`timescale 1ns/10ps
module ssb_monitor #(
  parameter int TICK_CYCLES = 20,
  parameter logic [13:0] CRAWL_SPEED = 14'h000a
) (
  input wire logic clk,  // Clock.
  input wire logic srst,  // Reset.
  input ssb_pkg::ssb_apb_req_t apbReq,  // APB request.
  input wire logic pready,  // APB ready.
  input wire logic [31:0] prdata,  // Read data.
  input wire logic pslverr,  // APB error.
  input wire logic servoOnCmd,  // On request.
  input wire logic servoOffCmd,  // Off request.
  input wire logic alarmPin,  // Alarm.
  input wire logic powerLossPin,  // Power loss.
  input wire logic [13:0] motorSpeed,  // Speed.
  input wire logic driveEnable,  // Drive on.
  input wire logic dynBrakeOn,  // Dynamic brake.
  input wire logic brakeRelease_n,  // Brake release.
  input wire logic [2:0] outCircuit_n  // Circuits.
);
  localparam int LIM = 100 * TICK_CYCLES + 8;
  int relCnt;
  logic onState;
  assign onState = driveEnable && !brakeRelease_n;
  // Counts cycles with the brake held released while the drive is off.
  always_ff @(posedge clk)
  begin
    if (srst || driveEnable || brakeRelease_n)
      relCnt <= 0;
    else
      relCnt <= relCnt + 1;
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);
  AST_RESET_IDLE: assert property (disable iff (1'b0)
    srst |=> brakeRelease_n && !driveEnable && !dynBrakeOn
      && outCircuit_n == 3'h7)
    else $error("outputs not idle after reset");
  AST_ON_RELEASE: assert property (
    $rose(driveEnable) |-> !brakeRelease_n)
    else $error("drive on without brake release");
  AST_ALARM_CUT: assert property (
    $rose(alarmPin) && driveEnable |-> ##[1:5] !driveEnable)
    else $error("alarm did not cut drive");
  AST_POWER_DB: assert property (
    powerLossPin [*6] |-> dynBrakeOn)
    else $error("power loss without dynamic brake");
  AST_STILL_OFF: assert property (
    onState && servoOffCmd && motorSpeed <= CRAWL_SPEED |=> brakeRelease_n)
    else $error("still stop did not apply brake");
  AST_MOVE_OFF: assert property (
    onState && servoOffCmd && motorSpeed > CRAWL_SPEED |=> !driveEnable)
    else $error("moving stop kept drive");
  AST_TIMEOUT: assert property (relCnt <= LIM)
    else $error("brake release outlived timeout");
  AST_DB_NO_DRIVE: assert property (dynBrakeOn |-> !driveEnable)
    else $error("dynamic brake with drive on");
  cover property (onState && servoOffCmd);
  cover property (dynBrakeOn);
  cover property ($fell(brakeRelease_n));
endmodule

bind ssb_sequencer ssb_monitor #(.TICK_CYCLES(TICK_CYCLES),
  .CRAWL_SPEED(CRAWL_SPEED)) mon_u (.clk(clk), .srst(srst),
  .apbReq(apbReq), .pready(pready), .prdata(prdata), .pslverr(pslverr),
  .servoOnCmd(servoOnCmd), .servoOffCmd(servoOffCmd), .alarmPin(alarmPin),
  .powerLossPin(powerLossPin), .motorSpeed(motorSpeed),
  .driveEnable(driveEnable), .dynBrakeOn(dynBrakeOn),
  .brakeRelease_n(brakeRelease_n), .outCircuit_n(outCircuit_n));

/* ssb_brake_relay.sv */
// Brake relay model that follows the release output after a pickup delay.
`timescale 1ns/10ps
module ssb_brake_relay #(
  parameter int DELAY = 3
) (
  input wire logic clk,  // Clock.
  input wire logic coil_n,  // Coil energised when low.
  output logic closed  // Brake supply contact closed.
);
  int cnt = 0;
  // A contact lags its coil, so a late close must not be read as a fault.
  always @(posedge clk)
  begin
    if (coil_n !== 1'b0)
    begin
      cnt <= 0;
      closed <= 1'b0;
    end
    else if (cnt < DELAY)
      cnt <= cnt + 1;
    else
      closed <= 1'b1;
  end
endmodule

/* test_ssb_sequencer.sv */
// Self-checking bench for the stop and brake sequencer.
`timescale 1ns/10ps
module test_ssb_sequencer;
  localparam int TK = 20;
  logic clk = 1'b0;
  logic srst = 1'b1;
  ssb_pkg::ssb_apb_req_t apbReq = '0;
  logic onCmd = 1'b0, offCmd = 1'b0, alarm = 1'b0, pwr = 1'b0;
  logic [13:0] speed = 14'h0000;
  logic pready, pslverr, drive, db, brk_n, relay;
  logic [31:0] prdata;
  logic [2:0] outN;
  int failures = 0, checkCount = 0, cyc = 0;
  always #4 clk = ~clk;
  ssb_sequencer #(.TICK_CYCLES(TK)) dut_u (.clk(clk), .srst(srst),
    .apbReq(apbReq), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .servoOnCmd(onCmd), .servoOffCmd(offCmd), .alarmPin(alarm),
    .powerLossPin(pwr), .motorSpeed(speed), .driveEnable(drive),
    .dynBrakeOn(db), .brakeRelease_n(brk_n), .outCircuit_n(outN));
  ssb_brake_relay #(.DELAY(3)) relay_u (.clk(clk), .coil_n(brk_n),
    .closed(relay));
  task complete_run;
    $display("failures=%0d checks=%0d", failures, checkCount);
    if (failures == 0 && checkCount > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      failures++;
      complete_run();
    end
  end
  task chk(input logic [31:0] g, e);
    checkCount++;
    if (g !== e)
    begin
      failures++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task chb(input logic g, e);
    chk({31'h0, g}, {31'h0, e});
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    apbReq <= '{1'b1, 1'b0, 1'b1, a, d};
    @(posedge clk);
    apbReq.penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    apbReq <= '0;
    @(posedge clk);
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e, input logic err);
    apbReq <= '{1'b1, 1'b0, 1'b0, a, 32'h0};
    @(posedge clk);
    apbReq.penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    chk(prdata, e);
    chb(pslverr, err);
    apbReq <= '0;
    @(posedge clk);
  endtask
  task rst;
    srst <= 1'b1;
    repeat (20) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
  endtask
  // Commands are spaced out; a host must not cycle the drive rapidly.
  task son;
    onCmd <= 1'b1;
    @(posedge clk);
    onCmd <= 1'b0;
    @(posedge clk);
  endtask
  task soff;
    offCmd <= 1'b1;
    @(posedge clk);
    offCmd <= 1'b0;
    @(posedge clk);
  endtask
  task t_regs;
    rst();
    chb(pready, 1'b1);
    chb(brk_n, 1'b1);
    chk({29'h0, outN}, 32'h7);
    rd(ssb_pkg::ADDR_CTRL, 32'h2, 1'b0);
    rd(ssb_pkg::ADDR_STOP_DELAY, 32'h0, 1'b0);
    rd(ssb_pkg::ADDR_SPEED_THR, 32'h64, 1'b0);
    rd(ssb_pkg::ADDR_TIMEOUT, 32'h32, 1'b0);
    rd(ssb_pkg::ADDR_MAX_SPEED, 32'hbb8, 1'b0);
    rd(8'h40, 32'h0, 1'b1);
    wr(ssb_pkg::ADDR_STOP_DELAY, 32'h3c);
    rd(ssb_pkg::ADDR_STOP_DELAY, 32'h32, 1'b0);
    wr(ssb_pkg::ADDR_SPEED_THR, 32'h4e20);
    rd(ssb_pkg::ADDR_SPEED_THR, 32'h2710, 1'b0);
  endtask
  task t_still(input logic [5:0] dl, input logic [1:0] md);
    rst();
    wr(ssb_pkg::ADDR_CTRL, 32'h10 | {30'h0, md});
    wr(ssb_pkg::ADDR_STOP_DELAY, {26'h0, dl});
    son();
    chb(brk_n, 1'b0);
    chb(outN[0], 1'b0);
    rd(ssb_pkg::ADDR_STATUS, 32'h15, 1'b0);
    repeat (4) @(posedge clk);
    chb(relay, 1'b1);
    soff();
    chb(brk_n, 1'b1);
    chb(drive, dl != 6'h00);
    chb(db, 1'b0);
    if (dl != 6'h00)
    begin
      repeat (int'(dl) * TK - 4) @(posedge clk);
      chb(drive, 1'b1);
      repeat (8) @(posedge clk);
      chb(drive, 1'b0);
    end
  endtask
  task t_move(input logic [1:0] md);
    rst();
    wr(ssb_pkg::ADDR_CTRL, {30'h0, md});
    speed <= 14'd1000;
    son();
    soff();
    chb(drive, 1'b0);
    chb(brk_n, 1'b0);
    chb(db, md < 2'h2);
    speed <= 14'd50;
    repeat (3) @(posedge clk);
    chb(brk_n, 1'b1);
    speed <= 14'd0;
    repeat (3) @(posedge clk);
    chb(db, md == 2'h0);
  endtask
  task t_timeout;
    rst();
    wr(ssb_pkg::ADDR_TIMEOUT, 32'h5);
    rd(ssb_pkg::ADDR_TIMEOUT, 32'ha, 1'b0);
    speed <= 14'd1000;
    son();
    soff();
    repeat (10 * TK - 6) @(posedge clk);
    chb(brk_n, 1'b0);
    repeat (12) @(posedge clk);
    chb(brk_n, 1'b1);
  endtask
  task t_maxspd;
    rst();
    wr(ssb_pkg::ADDR_MAX_SPEED, 32'h1f4);
    wr(ssb_pkg::ADDR_SPEED_THR, 32'h7d0);
    speed <= 14'd1000;
    son();
    soff();
    speed <= 14'd600;
    repeat (3) @(posedge clk);
    chb(brk_n, 1'b0);
    speed <= 14'd400;
    repeat (3) @(posedge clk);
    chb(brk_n, 1'b1);
  endtask
  task t_faults;
    rst();
    wr(ssb_pkg::ADDR_CTRL, 32'h6);
    speed <= 14'd1000;
    son();
    soff();
    chb(brk_n, 1'b1);
    chb(drive, 1'b0);
    rst();
    wr(ssb_pkg::ADDR_STOP_DELAY, 32'h32);
    speed <= 14'd0;
    son();
    alarm <= 1'b1;
    repeat (5) @(posedge clk);
    chb(drive, 1'b0);
    alarm <= 1'b0;
    rst();
    speed <= 14'd1000;
    son();
    alarm <= 1'b1;
    repeat (5) @(posedge clk);
    chb(drive, 1'b0);
    chb(brk_n, 1'b0);
    speed <= 14'd0;
    repeat (3) @(posedge clk);
    chb(brk_n, 1'b1);
    alarm <= 1'b0;
    rst();
    son();
    pwr <= 1'b1;
    repeat (6) @(posedge clk);
    chb(db, 1'b1);
    chb(drive, 1'b0);
    pwr <= 1'b0;
  endtask
  task t_or;
    rst();
    wr(ssb_pkg::ADDR_CTRL, 32'h22);
    wr(ssb_pkg::ADDR_OTHER_OUT, 32'h1);
    son();
    chk({29'h0, outN}, 32'h4);
    soff();
    wr(ssb_pkg::ADDR_OTHER_OUT, 32'h2);
    chk({29'h0, outN}, 32'h5);
    rd(ssb_pkg::ADDR_OTHER_OUT, 32'h2, 1'b0);
  endtask
  initial
  begin
    t_regs();
    t_still(6'h00, 2'h0);
    t_still(6'h02, 2'h2);
    for (int m = 0; m < 4; m++)
      t_move(m[1:0]);
    t_timeout();
    t_maxspd();
    t_faults();
    t_or();
    complete_run();
  end
endmodule
